//--- src/dps_switch_regs.vh
// register indices, field layouts and codes of the profile switching block
`ifndef DPS_SWITCH_REGS_VH
`define DPS_SWITCH_REGS_VH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define DPS_IDX_W             14
`define DPS_IDX_L0_IRQ_CLR    14'h200e
`define DPS_IDX_L1_IRQ_CLR    14'h2013
`define DPS_IDX_L0_ACT_FLAGS  14'h3009
`define DPS_IDX_L1_ACT_FLAGS  14'h300a
`define DPS_IDX_L0_IRQ_STAT   14'h3013
`define DPS_IDX_L1_IRQ_STAT   14'h3018
`define DPS_IDX_L0_MODE_LAST  14'h3101
`define DPS_IDX_L1_MODE_LAST  14'h3201
`define DPS_IDX_L0_CTRL       14'h2105
`define DPS_IDX_L1_CTRL       14'h2205
`define DPS_IDX_L0_PRIO       14'h1200
`define DPS_IDX_L1_PRIO       14'h1600
`define DPS_IDX_L0_IRQ_MASK   14'h2400
`define DPS_IDX_L1_IRQ_MASK   14'h2401

// ---------------------------------------------------------------
// field layouts and reset values
// ---------------------------------------------------------------
`define DPS_NPROF             6
`define DPS_PRI_W             5
`define DPS_PRIO_W            30
`define DPS_CTRL_W            7
`define DPS_CTRL_FREE         0
`define DPS_CTRL_HOLD         1
`define DPS_CTRL_MODE         3:2
`define DPS_CTRL_MAN          6:4
`define DPS_CTRL_RST          7'h00
`define DPS_PRIO_RST          30'h00000000
`define DPS_MASK_RST          6'h00

// ---------------------------------------------------------------
// selection modes and revert threshold
// ---------------------------------------------------------------
`define DPS_MODE_AUTO         2'h0
`define DPS_MODE_MAN_PRIO     2'h1
`define DPS_MODE_MAN_HOLD     2'h2
`define DPS_MODE_MAN_ONLY     2'h3
`define DPS_REVERT_GAP        6'h08

// ---------------------------------------------------------------
// bus responses
// ---------------------------------------------------------------
`define DPS_RESP_OKAY         2'h0
`define DPS_RESP_SLVERR       2'h2

`endif

//--- src/dps_prio_pick.v
// most favoured valid profile finder for one loop
`timescale 1ns/10ps
module dps_prio_pick #(
   parameter NPROF = 6,
   parameter PRI_W = 5
) (
   // profile state
   input  wire [NPROF-1:0]       valid_i,
   input  wire [NPROF*PRI_W-1:0] prio_i,
   // result
   output reg                    found_o,
   output reg  [2:0]             idx_o
);

   integer     p;
   reg [PRI_W-1:0] best;

   // lowest value wins, ties go to the lowest index
   always @* begin
      found_o = 1'b0;
      idx_o   = 3'h0;
      best    = {PRI_W{1'b1}};
      for (p = 0; p < NPROF; p = p + 1) begin
         if (valid_i[p] && (!found_o || prio_i[p*PRI_W +: PRI_W] < best)) begin
            found_o = 1'b1;
            idx_o   = p[2:0];
            best    = prio_i[p*PRI_W +: PRI_W];
         end
      end
   end

endmodule // dps_prio_pick

//--- src/dps_irq_latch.v
// sticky event bits, set wins over a clear in the same cycle
`timescale 1ns/10ps
module dps_irq_latch #(
   parameter W = 12
) (
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_n_i,
   // events and clears
   input  wire [W-1:0] set_i,
   input  wire [W-1:0] clr_i,
   // latched status
   output reg  [W-1:0] stat_o
);

   // a clear never swallows an event arriving in the same edge
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_o <= {W{1'b0}};
      end else begin
         stat_o <= (stat_o & ~clr_i) | set_i;
      end
   end

endmodule // dps_irq_latch

//--- src/dps_switch.v
// profile switching and active profile reporting for two loops, axi4-lite
`timescale 1ns/10ps
`include "dps_switch_regs.vh"
module dps_switch #(
   parameter NPROF = 6
) (
   // clock and reset
   input  wire                 ref_clk_i,
   input  wire                 arst_n_i,
   // profile validity from the validation logic, same clock
   input  wire [NPROF-1:0]     first_loop_valid_i,
   input  wire [NPROF-1:0]     second_loop_valid_i,
   // active profile flags
   output reg  [NPROF-1:0]     first_loop_active_o,
   output reg  [NPROF-1:0]     second_loop_active_o,
   // interrupt
   output reg                  irq_o,
   // axi4-lite write address
   input  wire                 s_axi_awvalid,
   output reg                  s_axi_awready,
   input  wire [15:0]          s_axi_awaddr,
   // axi4-lite write data
   input  wire                 s_axi_wvalid,
   output reg                  s_axi_wready,
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   // axi4-lite write response
   output reg                  s_axi_bvalid,
   input  wire                 s_axi_bready,
   output reg  [1:0]           s_axi_bresp,
   // axi4-lite read address
   input  wire                 s_axi_arvalid,
   output reg                  s_axi_arready,
   input  wire [15:0]          s_axi_araddr,
   // axi4-lite read data
   output reg                  s_axi_rvalid,
   input  wire                 s_axi_rready,
   output reg  [31:0]          s_axi_rdata,
   output reg  [1:0]           s_axi_rresp
);

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // priority of one profile out of the packed priority word
   function [`DPS_PRI_W-1:0] pri_of;
      input [`DPS_PRIO_W-1:0] pw;
      input [2:0]             idx;
      begin
         pri_of = pw[idx*`DPS_PRI_W +: `DPS_PRI_W];
      end
   endfunction

   // byte lane merge of a write into a stored word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   reg [1:0] rst_sync_q;
   wire      rst_n;

   // async assert, release after two edges
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ---------------------------------------------------------------
   // software registers and shared per-loop wires
   // ---------------------------------------------------------------
   reg  [`DPS_CTRL_W-1:0] ctrl_q [0:1];
   reg  [`DPS_PRIO_W-1:0] prio_q [0:1];
   reg  [NPROF-1:0]       mask_q [0:1];
   wire [2*NPROF-1:0]     flags_w;      // active flags, both loops
   wire [2*NPROF-1:0]     rise_w;       // zero-to-one of active flags
   wire [2*NPROF-1:0]     stat_w;       // latched activation status
   wire [2*7-1:0]         mode_last_w;  // index and mode bits, both loops
   wire [2*NPROF-1:0]     valid_w;
   reg  [2*NPROF-1:0]     clr_q;        // one-cycle clear strobes

   assign valid_w = {second_loop_valid_i, first_loop_valid_i};

   // ---------------------------------------------------------------
   // selection engine, one per loop
   // ---------------------------------------------------------------
   genvar l;
   generate
      for (l = 0; l < 2; l = l + 1) begin : g_loop
         reg                  on_q;        // closed loop on a profile
         reg  [2:0]           idx_q;       // current or last active index
         reg                  from_ok_q;
         reg  [2:0]           from_idx_q;
         reg  [`DPS_PRI_W-1:0] from_pri_q;
         reg                  hist_q;      // some profile was ever active
         reg                  hold_q;
         reg                  free_q;
         reg                  sw_q;
         reg  [NPROF-1:0]     flags_q;
         reg                  on_d;
         reg  [2:0]           idx_d;
         reg                  from_ok_d;
         reg  [2:0]           from_idx_d;
         reg  [`DPS_PRI_W-1:0] from_pri_d;
         reg                  hold_d;
         reg                  free_d;
         reg  [NPROF-1:0]     flags_d;
         reg                  auto_go;
         wire                 best_ok;
         wire [2:0]           best_idx;
         wire [NPROF-1:0]     vld;
         wire [2:0]           man;
         wire                 man_ok;
         wire                 cur_ok;
         wire                 revert_ok;
         wire [`DPS_PRI_W-1:0] cur_pri;

         assign vld     = valid_w[l*NPROF +: NPROF];
         assign man     = ctrl_q[l][`DPS_CTRL_MAN];
         assign man_ok  = (man < NPROF) && vld[man];
         assign cur_ok  = on_q && vld[idx_q];
         assign cur_pri = pri_of(prio_q[l], idx_q);
         // gap compared in six bits so the sum cannot wrap
         assign revert_ok = from_ok_q && vld[from_idx_q] &&
                            ({1'b0, cur_pri} >= {1'b0, from_pri_q} + `DPS_REVERT_GAP);

         dps_prio_pick #(
            .NPROF (NPROF),
            .PRI_W (`DPS_PRI_W)
         ) u_pick (
            .valid_i (vld),
            .prio_i  (prio_q[l]),
            .found_o (best_ok),
            .idx_o   (best_idx)
         );

         // next selection: forced modes first, then the mode field
         always @* begin
            on_d       = 1'b0;
            idx_d      = idx_q;
            from_ok_d  = from_ok_q;
            from_idx_d = from_idx_q;
            from_pri_d = from_pri_q;
            auto_go    = 1'b0;
            if (!ctrl_q[l][`DPS_CTRL_FREE] && !ctrl_q[l][`DPS_CTRL_HOLD]) begin
               case (ctrl_q[l][`DPS_CTRL_MODE])
                  `DPS_MODE_MAN_ONLY: begin
                     // debug mode: profile used without validation
                     if (man < NPROF) begin
                        on_d  = 1'b1;
                        idx_d = man;
                     end
                  end
                  `DPS_MODE_MAN_HOLD: begin
                     if (man_ok) begin
                        on_d  = 1'b1;
                        idx_d = man;
                     end
                  end
                  `DPS_MODE_MAN_PRIO: begin
                     if (man_ok) begin
                        on_d  = 1'b1;
                        idx_d = man;
                     end else begin
                        auto_go = 1'b1;
                     end
                  end
                  default: auto_go = 1'b1;
               endcase
            end
            if (auto_go) begin
               if (cur_ok && revert_ok) begin
                  on_d      = 1'b1;
                  idx_d     = from_idx_q;
                  from_ok_d = 1'b0;
               end else if (cur_ok) begin
                  on_d      = 1'b1;
               end else if (best_ok) begin
                  on_d  = 1'b1;
                  idx_d = best_idx;
                  if (on_q && best_idx != idx_q) begin
                     from_ok_d  = 1'b1;
                     from_idx_d = idx_q;
                     from_pri_d = cur_pri;
                  end
               end
            end else if (on_d) begin
               from_ok_d = 1'b0; // manual pick drops revert history
            end
            // open loop: free or hold bit forces its state, else holdover once history exists, else freerun
            free_d = ctrl_q[l][`DPS_CTRL_FREE] ||
                     (!on_d && !ctrl_q[l][`DPS_CTRL_HOLD] && !hist_q);
            hold_d = !on_d && !free_d;
            flags_d = {NPROF{1'b0}};
            flags_d[idx_d] = on_d;
         end

         // selection state
         always @(posedge ref_clk_i or negedge rst_n) begin
            if (!rst_n) begin
               on_q       <= 1'b0;
               idx_q      <= 3'h0;
               from_ok_q  <= 1'b0;
               from_idx_q <= 3'h0;
               from_pri_q <= {`DPS_PRI_W{1'b0}};
               hist_q     <= 1'b0;
               hold_q     <= 1'b0;
               free_q     <= 1'b0;
               sw_q       <= 1'b0;
               flags_q    <= {NPROF{1'b0}};
            end else begin
               on_q       <= on_d;
               idx_q      <= idx_d;
               from_ok_q  <= from_ok_d;
               from_idx_q <= from_idx_d;
               from_pri_q <= from_pri_d;
               hist_q     <= hist_q | on_d;
               hold_q     <= hold_d;
               free_q     <= free_d;
               sw_q       <= on_d && (!on_q || idx_d != idx_q);
               flags_q    <= flags_d;
            end
         end

         assign flags_w[l*NPROF +: NPROF] = flags_q;
         assign rise_w[l*NPROF +: NPROF]  = flags_d & ~flags_q;
         assign mode_last_w[l*7 +: 7]     = {idx_q, 1'b0, sw_q, hold_q, free_q};
      end
   endgenerate

   // ---------------------------------------------------------------
   // activation interrupts
   // ---------------------------------------------------------------
   dps_irq_latch #(
      .W (2*NPROF)
   ) u_irq (
      .clk_i   (ref_clk_i),
      .rst_n_i (rst_n),
      .set_i   (rise_w),
      .clr_i   (clr_q),
      .stat_o  (stat_w)
   );

   // outputs held in flops, interrupt one edge behind the status
   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_o                <= 1'b0;
         first_loop_active_o  <= {NPROF{1'b0}};
         second_loop_active_o <= {NPROF{1'b0}};
      end else begin
         irq_o <= |(stat_w & {mask_q[1], mask_q[0]});
         first_loop_active_o  <= flags_w[NPROF-1:0];
         second_loop_active_o <= flags_w[2*NPROF-1:NPROF];
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite write side
   // ---------------------------------------------------------------
   reg                  aw_held_q;
   reg                  w_held_q;
   reg [`DPS_IDX_W-1:0] aw_idx_q;
   reg [31:0]           wdata_q;
   reg [3:0]            wstrb_q;
   wire                 do_wr;
   reg                  wr_hit;
   wire [31:0]          prio_mrg0;
   wire [31:0]          prio_mrg1;

   // lane merge runs on a full word, the two spare top bits are dropped on purpose
   assign prio_mrg0 = merge({2'h0, prio_q[0]}, wdata_q, wstrb_q);
   assign prio_mrg1 = merge({2'h0, prio_q[1]}, wdata_q, wstrb_q);

   assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;

   // decode of writable indices
   always @* begin
      case (aw_idx_q)
         `DPS_IDX_L0_IRQ_CLR, `DPS_IDX_L1_IRQ_CLR,
         `DPS_IDX_L0_CTRL, `DPS_IDX_L1_CTRL,
         `DPS_IDX_L0_PRIO, `DPS_IDX_L1_PRIO,
         `DPS_IDX_L0_IRQ_MASK, `DPS_IDX_L1_IRQ_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // address and data taken in either order, response after both
   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_idx_q      <= {`DPS_IDX_W{1'b0}};
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DPS_RESP_OKAY;
         clr_q         <= {2*NPROF{1'b0}};
         ctrl_q[0]     <= `DPS_CTRL_RST;
         ctrl_q[1]     <= `DPS_CTRL_RST;
         prio_q[0]     <= `DPS_PRIO_RST;
         prio_q[1]     <= `DPS_PRIO_RST;
         mask_q[0]     <= `DPS_MASK_RST;
         mask_q[1]     <= `DPS_MASK_RST;
      end else begin
         clr_q <= {2*NPROF{1'b0}};
         if (s_axi_awready && s_axi_awvalid) begin
            aw_held_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[15:2];
         end
         if (s_axi_wready && s_axi_wvalid) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         s_axi_awready <= !aw_held_q && !(s_axi_awready && s_axi_awvalid) && !do_wr;
         s_axi_wready  <= !w_held_q && !(s_axi_wready && s_axi_wvalid) && !do_wr;
         if (do_wr) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `DPS_RESP_OKAY : `DPS_RESP_SLVERR;
            case (aw_idx_q)
               `DPS_IDX_L0_IRQ_CLR:
                  if (wstrb_q[0]) clr_q[NPROF-1:0] <= wdata_q[NPROF-1:0];
               `DPS_IDX_L1_IRQ_CLR:
                  if (wstrb_q[0]) clr_q[2*NPROF-1:NPROF] <= wdata_q[NPROF-1:0];
               `DPS_IDX_L0_CTRL:
                  if (wstrb_q[0]) ctrl_q[0] <= wdata_q[`DPS_CTRL_W-1:0];
               `DPS_IDX_L1_CTRL:
                  if (wstrb_q[0]) ctrl_q[1] <= wdata_q[`DPS_CTRL_W-1:0];
               `DPS_IDX_L0_PRIO:
                  prio_q[0] <= prio_mrg0[`DPS_PRIO_W-1:0];
               `DPS_IDX_L1_PRIO:
                  prio_q[1] <= prio_mrg1[`DPS_PRIO_W-1:0];
               `DPS_IDX_L0_IRQ_MASK:
                  if (wstrb_q[0]) mask_q[0] <= wdata_q[NPROF-1:0];
               `DPS_IDX_L1_IRQ_MASK:
                  if (wstrb_q[0]) mask_q[1] <= wdata_q[NPROF-1:0];
               default: ;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read side
   // ---------------------------------------------------------------
   reg [31:0] rd_val;
   reg        rd_hit;

   // read mux; narrow registers sit low, upper bits read zero
   always @* begin
      rd_hit = 1'b1;
      rd_val = 32'h00000000;
      case (s_axi_araddr[15:2])
         `DPS_IDX_L0_ACT_FLAGS: rd_val[NPROF-1:0] = flags_w[NPROF-1:0];
         `DPS_IDX_L1_ACT_FLAGS: rd_val[NPROF-1:0] = flags_w[2*NPROF-1:NPROF];
         `DPS_IDX_L0_IRQ_STAT:  rd_val[NPROF-1:0] = stat_w[NPROF-1:0];
         `DPS_IDX_L1_IRQ_STAT:  rd_val[NPROF-1:0] = stat_w[2*NPROF-1:NPROF];
         `DPS_IDX_L0_MODE_LAST: rd_val[6:0] = mode_last_w[6:0];
         `DPS_IDX_L1_MODE_LAST: rd_val[6:0] = mode_last_w[13:7];
         `DPS_IDX_L0_CTRL:      rd_val[`DPS_CTRL_W-1:0] = ctrl_q[0];
         `DPS_IDX_L1_CTRL:      rd_val[`DPS_CTRL_W-1:0] = ctrl_q[1];
         `DPS_IDX_L0_PRIO:      rd_val[`DPS_PRIO_W-1:0] = prio_q[0];
         `DPS_IDX_L1_PRIO:      rd_val[`DPS_PRIO_W-1:0] = prio_q[1];
         `DPS_IDX_L0_IRQ_MASK:  rd_val[NPROF-1:0] = mask_q[0];
         `DPS_IDX_L1_IRQ_MASK:  rd_val[NPROF-1:0] = mask_q[1];
         `DPS_IDX_L0_IRQ_CLR, `DPS_IDX_L1_IRQ_CLR: rd_val = 32'h00000000;
         default: rd_hit = 1'b0;
      endcase
   end

   // one read at a time, data registered at the address handshake
   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `DPS_RESP_OKAY;
      end else begin
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? `DPS_RESP_OKAY : `DPS_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else begin
            s_axi_arready <= !s_axi_rvalid;
         end
      end
   end

endmodule // dps_switch

//--- tb/dps_switch_checker.sv
// port assertions for the profile switch block
`timescale 1ns/10ps
module dps_switch_checker #(
   parameter NPROF = 6
) (
   // watched ports
   input wire             ref_clk_i,
   input wire             arst_n_i,
   input wire [NPROF-1:0] first_loop_active_o,
   input wire [NPROF-1:0] second_loop_active_o,
   input wire             irq_o,
   input wire             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire             s_axi_rvalid, s_axi_rready,
   input wire [1:0]       s_axi_bresp,
   input wire [31:0]      s_axi_rdata
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // handshakes; a clear or mask write is the only way irq may drop
   wire w_hs = s_axi_wvalid && s_axi_wready;
   sequence ar_hs; s_axi_arvalid && s_axi_arready; endsequence
   sequence wr_hs; s_axi_awvalid && s_axi_awready && w_hs; endsequence
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped early");
   a_write_answer: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (ar_hs |-> ##[1:2] s_axi_rvalid)
      else $error("read data late");
   a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_first_onehot: assert property ($onehot0(first_loop_active_o))
      else $error("first loop has two active profiles");
   a_second_onehot: assert property ($onehot0(second_loop_active_o))
      else $error("second loop has two active profiles");
   a_irq_clear_cause: assert property ($fell(irq_o) |-> $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2)) else $error("irq dropped without a write");
endmodule // dps_switch_checker

bind dps_switch dps_switch_checker #(.NPROF(NPROF)) u_chk (.*);

//--- tb/dps_switch_test.sv
// self-checking bench for the profile switch block
`timescale 1ns/10ps
`include "dps_switch_regs.vh"
module dps_switch_test;
   reg         ref_clk_i = 1'b0;
   reg         arst_n_i  = 1'b0;
   reg  [5:0]  v0        = 6'h03;
   reg  [5:0]  v1        = 6'h08;
   reg         awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   reg  [15:0] awa = 16'h0, ara = 16'h0;
   reg  [31:0] wd  = 32'h0;
   wire        awr, wr, bv, arr, rv, irq;
   wire [5:0]  a0, a1;
   wire [1:0]  br, rr;
   wire [31:0] rd;
   reg  [1:0]  resp;
   reg  [31:0] data;
   integer     fails = 0, checks = 0, i, n;
   // rows: ctrl word, loop0 validity, expected flags, expected mode/last byte
   localparam [31:0] ROWS [0:13] = '{32'h00030100, 32'h00020210, 32'h00030100,
      32'h00050100, 32'h00040420, 32'h00050420, 32'h00010100, 32'h00000002,
      32'h00202050, 32'h28010052, 32'h24010100, 32'h2c010420, 32'h01010021,
      32'h00010100};

   dps_switch DUT (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .first_loop_valid_i(v0),
      .second_loop_valid_i(v1), .first_loop_active_o(a0), .second_loop_active_o(a1),
      .irq_o(irq), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .s_axi_rdata(rd), .s_axi_rresp(rr));

   // 125 MHz system clock
   always #4 ref_clk_i = ~ref_clk_i;

   // ---------------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------------
   task summarize;
      begin
         if (fails == 0 && checks > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   task cmp(input string what, input [31:0] exp, input [31:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   // one write or read; ready sampled at the edge, so drops never race the slave
   task xfer(input wrt, input [13:0] idx, input [31:0] d);
      reg done;
      begin
         @(posedge ref_clk_i);
         awv <= wrt;
         wv <= wrt;
         bre <= wrt;
         arv <= !wrt;
         rre <= !wrt;
         awa <= {idx, 2'b00};
         ara <= {idx, 2'b00};
         wd <= d;
         done = 1'b0;
         n = 0;
         while (!done && n < 200) begin
            @(posedge ref_clk_i);
            n = n + 1;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (arv && arr) arv <= 1'b0;
            if ((bre && bv) || (rre && rv)) begin
               bre <= 1'b0;
               rre <= 1'b0;
               done = 1'b1;
               resp = wrt ? br : rr;
               data = rd;
            end
         end
         if (!done) begin
            fails = fails + 1;
            summarize;
         end
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      xfer(1'b0, `DPS_IDX_L0_PRIO, 32'h0);
      cmp("prio reset", 32'h0, data);
      xfer(1'b1, `DPS_IDX_L0_PRIO, 32'h1d00);
      for (i = 0; i < 14; i = i + 1) begin
         xfer(1'b1, `DPS_IDX_L0_CTRL, ROWS[i][31:24]);
         v0 <= ROWS[i][21:16];
         repeat (3) @(posedge ref_clk_i);
         cmp("active", ROWS[i][13:8], a0);
         xfer(1'b0, `DPS_IDX_L0_ACT_FLAGS, 32'h0);
         cmp("flags", ROWS[i][13:8], data);
         xfer(1'b0, `DPS_IDX_L0_MODE_LAST, 32'h0);
         cmp("mode last", ROWS[i][7:0], data);
      end
      xfer(1'b0, `DPS_IDX_L1_ACT_FLAGS, 32'h0);
      cmp("flags1", 32'h8, data);
      cmp("active1", 32'h8, a1);
      // sticky status, masking and partial clears
      xfer(1'b1, `DPS_IDX_L0_IRQ_CLR, 32'h3f);
      v0 <= 6'h20;
      repeat (3) @(posedge ref_clk_i);
      v0 <= 6'h01;
      repeat (3) @(posedge ref_clk_i);
      xfer(1'b0, `DPS_IDX_L0_IRQ_STAT, 32'h0);
      cmp("status", 32'h21, data);
      cmp("irq masked", 32'h0, irq);
      xfer(1'b1, `DPS_IDX_L0_IRQ_MASK, 32'h3f);
      xfer(1'b1, `DPS_IDX_L0_IRQ_CLR, 32'h01);
      repeat (3) @(posedge ref_clk_i);
      cmp("irq", 32'h1, irq);
      xfer(1'b0, `DPS_IDX_L0_IRQ_STAT, 32'h0);
      cmp("status", 32'h20, data);
      xfer(1'b1, `DPS_IDX_L0_IRQ_CLR, 32'h20);
      repeat (3) @(posedge ref_clk_i);
      cmp("irq clear", 32'h0, irq);
      // read-only, write-only and unmapped places
      xfer(1'b1, `DPS_IDX_L0_ACT_FLAGS, 32'h0);
      cmp("ro resp", `DPS_RESP_SLVERR, resp);
      xfer(1'b0, `DPS_IDX_L0_IRQ_CLR, 32'h0);
      cmp("clr read", 32'h0, data);
      xfer(1'b0, 14'h0000, 32'h0);
      cmp("unmapped resp", `DPS_RESP_SLVERR, resp);
      cmp("unmapped data", 32'h0, data);
      // mid-run reset: outputs drop at once, then profile 0 is picked and latched again
      arst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      cmp("reset active", 32'h0, a0);
      cmp("reset irq", 32'h0, irq);
      arst_n_i <= 1'b1;
      xfer(1'b0, `DPS_IDX_L0_IRQ_STAT, 32'h0);
      cmp("reset status", 32'h01, data);
      xfer(1'b0, `DPS_IDX_L0_MODE_LAST, 32'h0);
      cmp("reset mode last", 32'h00, data);
      summarize;
   end
endmodule // dps_switch_test
